// [include/rsp_bus_if.sv]
// Two-wire bus between the bus master and the rtc serial slave port.
// SCL is driven only by the master; SDA is open drain with active-low enables.
`timescale 1ns/1ps
interface rsp_bus_if;
	logic scl;          // Serial clock, master driven
	logic sda_m_o;      // Master data level when enabled
	logic sda_m_oe_b;   // Master pulls SDA when low
	logic sda_s_o;      // Slave data level when enabled
	logic sda_s_oe_b;   // Slave pulls SDA when low
	logic sda;          // Resolved line, pulled up when nobody drives low

	// ----------------------------------------------------------------
	// Wired-AND resolution of SDA
	// ----------------------------------------------------------------
	assign sda = !((!sda_m_oe_b && !sda_m_o) || (!sda_s_oe_b && !sda_s_o));

	modport master (output scl, output sda_m_o, output sda_m_oe_b, input sda);
	modport slave  (input scl, output sda_s_o, output sda_s_oe_b, input sda);
endinterface

// [include/rsp_pkg.sv]
// Shared constants for the rtc serial slave port and its bus master.
// Assumes one 25 MHz clock on both ends and a synchronous view of the bus.
package rsp_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_REC_NS      = 1000000;   // Recovery time after supply returns
	localparam int REC_CYCLES    = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_QTR_NS    = 625;       // Quarter of a 400 kHz bit period
	localparam int QTR_CYCLES    = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR7 = 7'h68;   // D0h with the direction bit stripped
	localparam logic [4:0] LOC_COUNT   = 5'h14;   // 20 byte locations
	localparam logic [4:0] CLOCK_LAST  = 5'h07;   // Timekeeping locations 00h..07h
	localparam logic [4:0] PTR_RESET   = 5'h00;

	// ----------------------------------------------------------------
	// Master command codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_STOP  = 2'h1,
		CMD_WRITE = 2'h2,
		CMD_READ  = 2'h3
	} rsp_cmd_t;

endpackage

// [src/rsp_master.sv]
// Bus master end: runs START, STOP and byte commands on the two-wire bus.
// Assumes a single master; SCL is push-pull, SDA open drain.
`timescale 1ns/1ps
module rsp_master #(
	parameter int QTR = rsp_pkg::QTR_CYCLES
) (
	input  wire logic               clock,
	input  wire logic               rst_b,
	rsp_bus_if.master               bus,
	input  wire logic               cmd_valid,
	input  wire rsp_pkg::rsp_cmd_t  cmd_op,
	input  wire logic [7:0]         cmd_data,
	input  wire logic               cmd_nack,
	output logic                    cmd_ready,
	output logic                    rsp_valid,
	output logic      [7:0]         rsp_data,
	output logic                    rsp_nack
);
	import rsp_pkg::*;

	localparam int TW = $clog2(QTR + 1);

	typedef enum logic [0:0] {
		M_IDLE = 1'h0,
		M_RUN  = 1'h1
	} rsp_mst_t;

	typedef struct packed {
		rsp_mst_t  st;
		rsp_cmd_t  op;
		logic [1:0]  ph;
		logic [TW-1:0] tick;
		logic [3:0]  bitn;
		logic [7:0]  shf;
		logic        nack;
		logic        scl;
		logic        oe_b;
		logic        own;
		logic        rdy;
		logic        rsp_valid;
		logic [7:0]  rsp_data;
		logic        rsp_nack;
	} rsp_mreg_t;

	rsp_mreg_t r_ff;
	rsp_mreg_t nxt_r;

	// ----------------------------------------------------------------
	// Command sequencer, four quarter phases per step
	// ----------------------------------------------------------------
	always_comb begin
		nxt_r           = r_ff;
		nxt_r.rsp_valid = 1'b0;
		case (r_ff.st)
			M_IDLE: begin
				// A fresh START waits for an idle bus; a repeated one does not
				if (cmd_valid && !(cmd_op == CMD_START && !r_ff.own && !(bus.sda && bus.scl))) begin
					nxt_r.op   = cmd_op;
					nxt_r.shf  = cmd_data;
					nxt_r.nack = cmd_nack;
					nxt_r.ph   = 2'h0;
					nxt_r.tick = '0;
					nxt_r.bitn = 4'h0;
					nxt_r.rdy  = 1'b0;
					nxt_r.st   = M_RUN;
				end
			end
			M_RUN: begin
				if (r_ff.tick != TW'(QTR - 1)) begin
					nxt_r.tick = r_ff.tick + 1'b1;
				end else begin
					nxt_r.tick = '0;
					nxt_r.ph   = r_ff.ph + 2'h1;
					case (r_ff.ph)
						2'h0: begin
							// Data moves only in the low phase of SCL
							if (r_ff.op == CMD_START) nxt_r.oe_b = 1'b1;
							else if (r_ff.op == CMD_STOP) nxt_r.oe_b = 1'b0;
							else if (r_ff.bitn != 4'h8) nxt_r.oe_b =
								(r_ff.op == CMD_WRITE) ? r_ff.shf[7] : 1'b1;
							else nxt_r.oe_b = (r_ff.op == CMD_WRITE) ? 1'b1 : r_ff.nack;
						end
						2'h1: begin
							nxt_r.scl = 1'b1;
						end
						2'h2: begin
							if (r_ff.op == CMD_START) nxt_r.oe_b = 1'b0;
							else if (r_ff.op == CMD_STOP) nxt_r.oe_b = 1'b1;
							else if (r_ff.bitn != 4'h8) nxt_r.shf = {r_ff.shf[6:0], bus.sda};
							else nxt_r.rsp_nack = bus.sda;
						end
						default: begin
							if (r_ff.op != CMD_STOP) nxt_r.scl = 1'b0;
							if ((r_ff.op == CMD_WRITE || r_ff.op == CMD_READ) && r_ff.bitn != 4'h8) begin
								nxt_r.bitn = r_ff.bitn + 4'h1;
							end else begin
								nxt_r.st        = M_IDLE;
								nxt_r.rdy       = 1'b1;
								nxt_r.rsp_valid = 1'b1;
								nxt_r.rsp_data  = r_ff.shf;
								nxt_r.own       = (r_ff.op != CMD_STOP);
							end
						end
					endcase
				end
			end
			default: begin
				nxt_r.st = M_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			r_ff      <= '0;
			r_ff.st   <= M_IDLE;
			r_ff.scl  <= 1'b1;
			r_ff.oe_b <= 1'b1;
			r_ff.rdy  <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign bus.scl        = r_ff.scl;
	assign bus.sda_m_o    = 1'b0;
	assign bus.sda_m_oe_b = r_ff.oe_b;
	assign cmd_ready      = r_ff.rdy;
	assign rsp_valid      = r_ff.rsp_valid;
	assign rsp_data       = r_ff.rsp_data;
	assign rsp_nack       = r_ff.rsp_nack;
endmodule

// [src/rsp_slave.sv]
// Serial slave port of the real-time clock: bus decode, pointer, transfer freeze.
// Assumes the bus is sampled synchronously and the location store sits outside.
`timescale 1ns/1ps
module rsp_slave #(
	parameter int REC_CYCLES = rsp_pkg::REC_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	rsp_bus_if.slave         bus,
	input  wire logic        main_supply_ok,
	input  wire logic [7:0]  rd_data,
	output logic      [4:0]  pointer_start_location,
	output logic             wr_stb,
	output logic      [4:0]  wr_addr,
	output logic      [7:0]  wr_data,
	output logic             divider_reset,
	output logic             freeze_transfer,
	output logic             locked_out
);
	import rsp_pkg::*;

	localparam int REC_W = $clog2(REC_CYCLES + 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_ADDR   = 3'h1,
		S_AACK   = 3'h2,
		S_RECV   = 3'h3,
		S_DACK   = 3'h4,
		S_SEND   = 3'h5,
		S_MACK   = 3'h6,
		S_IGNORE = 3'h7
	} rsp_sst_t;

	typedef struct packed {
		rsp_sst_t         st;
		logic             scl_q;
		logic             sda_q;
		logic [3:0]       cnt;
		logic [7:0]       shf;
		logic             rw;
		logic             is_ptr;
		logic             macked;
		logic [4:0]       ptr;
		logic             oe_b;
		logic             sda_o;
		logic             wr_stb;
		logic [4:0]       wr_addr;
		logic [7:0]       wr_data;
		logic             div_rst;
		logic             freeze;
		logic             locked;
		logic [REC_W-1:0] rec;
	} rsp_sreg_t;

	rsp_sreg_t r_ff;
	rsp_sreg_t nxt_r;
	logic      rise;
	logic      fall;
	logic      start;
	logic      stop;

	// Next location, wrapping from the last one back to the first
	function automatic logic [4:0] ptr_inc(input logic [4:0] p);
		return (p == LOC_COUNT - 5'h01) ? 5'h00 : p + 5'h01;
	endfunction

	function automatic logic is_clock(input logic [4:0] p);
		return p <= CLOCK_LAST;
	endfunction

	// ----------------------------------------------------------------
	// Bus condition decode
	// ----------------------------------------------------------------
	// Conditions compare this sample with the last, so glitches under one clock are missed
	assign rise  = bus.scl && !r_ff.scl_q;
	assign fall  = !bus.scl && r_ff.scl_q;
	assign start = bus.scl && r_ff.scl_q && r_ff.sda_q && !bus.sda;
	assign stop  = bus.scl && r_ff.scl_q && !r_ff.sda_q && bus.sda;

	// ----------------------------------------------------------------
	// Protocol engine
	// ----------------------------------------------------------------
	always_comb begin
		nxt_r         = r_ff;
		nxt_r.scl_q   = bus.scl;
		nxt_r.sda_q   = bus.sda;
		nxt_r.wr_stb  = 1'b0;
		nxt_r.div_rst = 1'b0;
		nxt_r.sda_o   = 1'b0;
		if (!main_supply_ok) begin
			// Drop everything and hold the recovery count full while supply is low
			nxt_r.st     = S_IDLE;
			nxt_r.ptr    = PTR_RESET;
			nxt_r.oe_b   = 1'b1;
			nxt_r.locked = 1'b1;
			nxt_r.rec    = REC_W'(REC_CYCLES);
		end else if (r_ff.rec != '0) begin
			nxt_r.rec    = r_ff.rec - 1'b1;
			nxt_r.locked = 1'b1;
		end else begin
			nxt_r.locked = 1'b0;
			if (start) begin
				// A repeated START is honoured from any state
				nxt_r.st   = S_ADDR;
				nxt_r.cnt  = 4'h0;
				nxt_r.oe_b = 1'b1;
			end else if (stop) begin
				nxt_r.st   = S_IDLE;
				nxt_r.oe_b = 1'b1;
			end else begin
				case (r_ff.st)
					S_ADDR, S_RECV: begin
						if (rise && r_ff.cnt != 4'h8) begin
							nxt_r.shf = {r_ff.shf[6:0], bus.sda};
							nxt_r.cnt = r_ff.cnt + 4'h1;
						end else if (fall && r_ff.cnt == 4'h8) begin
							if (r_ff.st == S_ADDR && r_ff.shf[7:1] != SLAVE_ADDR7) begin
								nxt_r.st = S_IGNORE;
							end else if (r_ff.st == S_ADDR) begin
								nxt_r.oe_b = 1'b0;
								nxt_r.rw   = r_ff.shf[0];
								nxt_r.st   = S_AACK;
							end else begin
								nxt_r.oe_b = 1'b0;
								nxt_r.st   = S_DACK;
							end
						end
					end
					S_AACK: begin
						if (fall) begin
							if (r_ff.rw) begin
								// First bit goes out on the same low phase the ack ends
								nxt_r.shf  = {rd_data[6:0], 1'b0};
								nxt_r.oe_b = rd_data[7];
								nxt_r.cnt  = 4'h1;
								nxt_r.st   = S_SEND;
							end else begin
								nxt_r.oe_b   = 1'b1;
								nxt_r.cnt    = 4'h0;
								nxt_r.is_ptr = 1'b1;
								nxt_r.st     = S_RECV;
							end
						end
					end
					S_DACK: begin
						if (rise) begin
							if (r_ff.is_ptr) begin
								// Out-of-range word addresses fold to the first location
								nxt_r.ptr = (r_ff.shf < {3'h0, LOC_COUNT}) ?
									r_ff.shf[4:0] : PTR_RESET;
							end else begin
								nxt_r.wr_stb  = 1'b1;
								nxt_r.wr_addr = r_ff.ptr;
								nxt_r.wr_data = r_ff.shf;
								nxt_r.div_rst = is_clock(r_ff.ptr);
								nxt_r.ptr     = ptr_inc(r_ff.ptr);
							end
							nxt_r.is_ptr = 1'b0;
						end else if (fall) begin
							nxt_r.oe_b = 1'b1;
							nxt_r.cnt  = 4'h0;
							nxt_r.st   = S_RECV;
						end
					end
					S_SEND: begin
						if (fall) begin
							if (r_ff.cnt == 4'h8) begin
								nxt_r.oe_b = 1'b1;
								nxt_r.st   = S_MACK;
							end else begin
								nxt_r.oe_b = r_ff.shf[7];
								nxt_r.shf  = {r_ff.shf[6:0], 1'b0};
								nxt_r.cnt  = r_ff.cnt + 4'h1;
							end
						end
					end
					S_MACK: begin
						if (rise) begin
							nxt_r.macked = !bus.sda;
							nxt_r.ptr    = ptr_inc(r_ff.ptr);
						end else if (fall) begin
							if (r_ff.macked) begin
								nxt_r.shf  = {rd_data[6:0], 1'b0};
								nxt_r.oe_b = rd_data[7];
								nxt_r.cnt  = 4'h1;
								nxt_r.st   = S_SEND;
							end else begin
								nxt_r.st = S_IGNORE;
							end
						end
					end
					S_IDLE, S_IGNORE: begin
						nxt_r.oe_b = 1'b1;
					end
					default: begin
						nxt_r.st   = S_IDLE;
						nxt_r.oe_b = 1'b1;
					end
				endcase
			end
		end
		// Copy is held while an access sits on a timekeeping location
		nxt_r.freeze = (nxt_r.st != S_IDLE) && (nxt_r.st != S_IGNORE) &&
			is_clock(nxt_r.ptr);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			r_ff        <= '0;
			r_ff.st     <= S_IDLE;
			r_ff.scl_q  <= 1'b1;
			r_ff.sda_q  <= 1'b1;
			r_ff.oe_b   <= 1'b1;
			r_ff.ptr    <= PTR_RESET;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign bus.sda_s_o            = r_ff.sda_o;
	assign bus.sda_s_oe_b         = r_ff.oe_b;
	assign pointer_start_location = r_ff.ptr;
	assign wr_stb                 = r_ff.wr_stb;
	assign wr_addr                = r_ff.wr_addr;
	assign wr_data                = r_ff.wr_data;
	assign divider_reset          = r_ff.div_rst;
	assign freeze_transfer        = r_ff.freeze;
	assign locked_out             = r_ff.locked;
endmodule

// [testbench/rsp_properties.sv]
// Concurrent checks on the two-wire bus between master and slave ends.
// Assumes the master runs with a quarter bit period of four clocks.
`timescale 1ns/1ps
module rsp_properties (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_m_o,
	input wire logic sda_m_oe_b,
	input wire logic sda_s_o,
	input wire logic sda_s_oe_b,
	input wire logic sda
);
	// ------------------------------------------------
	// Bus checks, one clock domain
	// ------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Bus rules: idle after reset, slave SDA edges inside SCL low phases, START/STOP, SCL timing, open drain
	idle_after_reset_a: assert property ($rose(rst_b) |-> scl && sda)
		else $error("bus not idle after reset");
	slave_pull_low_a: assert property ($fell(sda_s_oe_b) |-> !scl)
		else $error("slave grabbed SDA while SCL high");
	slave_release_low_a: assert property ($rose(sda_s_oe_b) |-> !scl)
		else $error("slave released SDA while SCL high");
	ack_held_low_a: assert property ($rose(scl) && !sda_s_oe_b |-> (!sda_s_oe_b)[*8])
		else $error("slave low not held across SCL high");
	slave_drive_bound_a: assert property ($fell(sda_s_oe_b) |-> ##[1:200] $rose(sda_s_oe_b))
		else $error("slave holds SDA too long");
	start_slave_quiet_a: assert property (scl && $fell(sda) |-> sda_s_oe_b)
		else $error("slave drove SDA at START");
	stop_slave_quiet_a: assert property (scl && $rose(sda) |-> sda_s_oe_b[*4])
		else $error("slave drove SDA around STOP");
	start_then_clock_a: assert property (scl && $past(scl) && $fell(sda) |-> ##[1:8] !scl)
		else $error("SCL not pulled low after START");
	scl_high_phase_a: assert property ($rose(scl) |-> scl[*8])
		else $error("SCL high phase too short");
	open_drain_a: assert property (!sda_s_oe_b || !sda_m_oe_b |-> !sda)
		else $error("SDA not low while pulled");

	// Main scenarios reached
	cov_start: cover property (scl && $fell(sda));
	cov_stop: cover property (scl && $rose(sda));
	cov_ack: cover property ($rose(scl) && !sda_s_oe_b);
endmodule

// [testbench/rtc_serial_slave_port_tb.sv]
// Self-checking bench: master and slave ends joined on one bus.
// Assumes no other bus party; the bench models the location store.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module rtc_serial_slave_port_tb;
	import rsp_pkg::*;
	typedef struct packed {logic [4:0] loc; logic [7:0] dat; logic div; logic [4:0] nxt;} rsp_row_t;
	localparam rsp_row_t ROWS [4] = '{'{5'h00, 8'hA5, 1'b1, 5'h01}, '{5'h07, 8'h3C, 1'b1, 5'h08},
		'{5'h08, 8'h5A, 1'b0, 5'h09}, '{5'h13, 8'hC3, 1'b0, 5'h00}};
	logic       clock          = 1'b0;
	logic       rst_b          = 1'b0;
	logic       main_supply_ok = 1'b1;
	logic       cmd_valid      = 1'b0;
	rsp_cmd_t   cmd_op         = CMD_START;
	logic [7:0] cmd_data       = 8'h00;
	logic       cmd_nack       = 1'b0;
	logic [7:0] mem [20];
	logic [7:0] rd_data, wr_data, rsp_data;
	logic [4:0] ptr, wr_addr;
	logic       wr_stb, div_rst, freeze, locked, cmd_ready, rsp_valid, rsp_nack, div_seen;
	int         err_total  = 0;
	int         n_compared = 0;

	// ------------------------------------------------
	// Design ends and checker
	// ------------------------------------------------
	rsp_bus_if bus ();
	rsp_slave #(.REC_CYCLES(400)) rsp_slave_inst (.clock(clock), .rst_b(rst_b), .bus(bus),
		.main_supply_ok(main_supply_ok), .rd_data(rd_data), .pointer_start_location(ptr),
		.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .divider_reset(div_rst),
		.freeze_transfer(freeze), .locked_out(locked));
	rsp_master #(.QTR(4)) rsp_master_inst (.clock(clock), .rst_b(rst_b), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
	rsp_properties rsp_properties_inst (.clock(clock), .rst_b(rst_b), .scl(bus.scl),
		.sda_m_o(bus.sda_m_o), .sda_m_oe_b(bus.sda_m_oe_b), .sda_s_o(bus.sda_s_o),
		.sda_s_oe_b(bus.sda_s_oe_b), .sda(bus.sda));

	// Clock and the location store; reads must be combinational from the pointer
	initial forever #20 clock = ~clock;
	assign rd_data = mem[ptr];
	always @(posedge clock) begin
		if (wr_stb === 1'b1) begin
			mem[wr_addr] <= wr_data;
			div_seen <= div_rst;
		end
	end

	// ------------------------------------------------
	// Command tasks
	// ------------------------------------------------
	// Hold the request until cmd_ready drops, then wait for the answer pulse
	task cmd(input rsp_cmd_t op, input logic [7:0] d, input logic nk);
		cmd_op <= op;
		cmd_data <= d;
		cmd_nack <= nk;
		cmd_valid <= 1'b1;
		@(posedge clock);
		while (cmd_ready === 1'b1) @(posedge clock);
		cmd_valid <= 1'b0;
		while (rsp_valid !== 1'b1) @(posedge clock);
	endtask
	task wb(input logic [7:0] d, input logic nk);
		cmd(CMD_WRITE, d, 1'b0);
		`CHK("ack", nk, rsp_nack)
	endtask
	task rd(input logic nk, input logic [7:0] e);
		cmd(CMD_READ, 8'h00, nk);
		`CHK("rdata", e, rsp_data)
	endtask
	task point(input logic [4:0] loc);
		cmd(CMD_START, 8'h00, 1'b0);
		wb(8'hD0, 1'b0);
		wb({3'h0, loc}, 1'b0);
	endtask
	task stop_test;
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		for (int i = 0; i < 20; i++) mem[i] = 8'h00;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		`CHK("ptr", 5'h00, ptr)
		`CHK("idle", 2'h3, {bus.scl, bus.sda})
		`CHK("lock", 1'b0, locked)
		// Table rows: write one location, then read it back through a pointer write
		foreach (ROWS[i]) begin
			point(ROWS[i].loc);
			wb(ROWS[i].dat, 1'b0);
			cmd(CMD_STOP, 8'h00, 1'b0);
			`CHK("waddr", ROWS[i].loc, wr_addr)
			`CHK("wdata", ROWS[i].dat, wr_data)
			`CHK("div", ROWS[i].div, div_seen)
			`CHK("ptr", ROWS[i].nxt, ptr)
			point(ROWS[i].loc);
			cmd(CMD_START, 8'h00, 1'b0);
			wb(8'hD1, 1'b0);
			rd(1'b1, ROWS[i].dat);
			cmd(CMD_STOP, 8'h00, 1'b0);
			`CHK("ptr", ROWS[i].nxt, ptr)
		end
		// Read from the current pointer, which wrapped to zero
		cmd(CMD_START, 8'h00, 1'b0);
		wb(8'hD1, 1'b0);
		rd(1'b0, 8'hA5);
		rd(1'b1, 8'h00);
		cmd(CMD_STOP, 8'h00, 1'b0);
		`CHK("ptr", 5'h02, ptr)
		// Burst write across the clock boundary, then read it back
		point(5'h06);
		`CHK("frz", 1'b1, freeze)
		wb(8'h11, 1'b0);
		wb(8'h22, 1'b0);
		`CHK("frz", 1'b0, freeze)
		`CHK("div", 1'b1, div_seen)
		point(5'h06);
		cmd(CMD_START, 8'h00, 1'b0);
		wb(8'hD1, 1'b0);
		rd(1'b0, 8'h11);
		`CHK("frz", 1'b1, freeze)
		rd(1'b1, 8'h22);
		`CHK("frz", 1'b0, freeze)
		point(5'h02);
		cmd(CMD_STOP, 8'h00, 1'b0);
		`CHK("frz", 1'b0, freeze)
		// Foreign address is ignored until the next START
		cmd(CMD_START, 8'h00, 1'b0);
		wb(8'hA0, 1'b1);
		wb(8'h55, 1'b1);
		`CHK("frz", 1'b0, freeze)
		cmd(CMD_STOP, 8'h00, 1'b0);
		`CHK("ptr", 5'h02, ptr)
		// Word address past the last location folds back to the first
		point(5'h1F);
		cmd(CMD_STOP, 8'h00, 1'b0);
		`CHK("ptr", 5'h00, ptr)
		// Supply drop in mid-transfer, then the recovery lockout
		point(5'h03);
		main_supply_ok <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK("lock", 1'b1, locked)
		`CHK("ptr", 5'h00, ptr)
		wb(8'h55, 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0);
		main_supply_ok <= 1'b1;
		cmd(CMD_START, 8'h00, 1'b0);
		wb(8'hD0, 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0);
		while (locked === 1'b1) @(posedge clock);
		point(5'h03);
		cmd(CMD_STOP, 8'h00, 1'b0);
		`CHK("ptr", 5'h03, ptr)
		stop_test();
	end

	// Watchdog well past the expected run of about 9000 cycles
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		$display("[ERR] run exp done got hang");
		stop_test();
	end
endmodule
